//--- bench/card_socket_status_power_regs_tb_top.sv
// Purpose: Self-checking bench for the status and power register bank
// Assumes: Default parameters of the bank, two sockets
// Notes:   Inputs move on the falling edge; one idle cycle between accesses except in wr_rd
`timescale 1ns/1ps
module card_socket_status_power_regs_tb_top;
  logic                  clk_sys;     // System clock
  logic                  rst;         // Reset, active high
  logic                  hst_sel;     // Chip select
  logic                  hst_addr;    // Selector or data byte
  logic                  hst_rd;      // Read strobe
  logic                  hst_wr;      // Write strobe
  logic [7:0]            hst_wdata;   // Write byte
  logic [7:0]            hst_rdata;   // Read byte
  logic                  hst_rvalid;  // Read byte valid
  logic [6:0]            cfg [2];     // Card setup per socket
  cssp_pkg::cssp_pins_t  pins [2];    // Pins from the cards
  cssp_pkg::cssp_power_t power [2];   // Power fields out
  int                    bad_count;   // Mismatches
  int                    compares;    // Comparisons made
  localparam logic [7:0] REV_EXP = {2'h1, 1'b0, 5'h04}; // Identity byte
  localparam logic [6:0] PAT [4] = '{7'h7F, 7'h00, 7'h55, 7'h2A}; // Pin patterns

  // One card per socket
  for (genvar s = 0; s < 2; s++) begin : g_card
    cssp_card_model card_u (.vpp_ok(cfg[s][6]), .ready(cfg[s][5]), .wp(cfg[s][4]),
      .seat(cfg[s][3:2]), .batt(cfg[s][1:0]), .pins(pins[s]));
  end

  cssp_status_power_regs dut_u (.clk_sys(clk_sys), .rst(rst), .hst_sel(hst_sel),
    .hst_addr(hst_addr), .hst_rd(hst_rd), .hst_wr(hst_wr), .hst_wdata(hst_wdata),
    .hst_rdata(hst_rdata), .hst_rvalid(hst_rvalid), .sock_pins(pins), .sock_power(power));

  // Free-running 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle, strobe dropped a cycle later
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge clk_sys);
    hst_sel = 1'b1; hst_addr = a; hst_wr = 1'b1; hst_wdata = d;
    @(negedge clk_sys);
    hst_sel = 1'b0; hst_wr = 1'b0;
  endtask

  // One read; data and valid stand in the cycle after the strobe
  task automatic rd(input logic a, input logic [7:0] exp);
    @(negedge clk_sys);
    hst_sel = 1'b1; hst_addr = a; hst_rd = 1'b1;
    @(negedge clk_sys);
    hst_sel = 1'b0; hst_rd = 1'b0;
    chk({7'h00, hst_rvalid}, 8'h01);
    chk(hst_rdata, exp);
  endtask

  task automatic rd_reg(input logic [7:0] sel, input logic [7:0] exp);
    wr(1'b0, sel);
    rd(1'b1, exp);
  endtask

  task automatic wr_reg(input logic [7:0] sel, input logic [7:0] d);
    wr(1'b0, sel);
    wr(1'b1, d);
  endtask

  // Data write and data read on consecutive edges, no idle cycle between
  task automatic wr_rd(input logic [7:0] sel, input logic [7:0] d, input logic [7:0] exp);
    wr(1'b0, sel);
    @(negedge clk_sys);
    hst_sel = 1'b1; hst_addr = 1'b1; hst_wr = 1'b1; hst_wdata = d;
    @(negedge clk_sys);
    hst_wr = 1'b0; hst_rd = 1'b1;
    @(negedge clk_sys);
    hst_sel = 1'b0; hst_rd = 1'b0;
    chk({7'h00, hst_rvalid}, 8'h01);
    chk(hst_rdata, exp);
  endtask

  task automatic test_reset();
    rd(1'b0, 8'h00);
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h42, 8'h00);
    chk(power[1], 8'h00);
    $display("test reset done");
  endtask

  task automatic test_selector();
    wr(1'b0, 8'hC5);
    rd(1'b0, 8'hC5);
    wr(1'b0, 8'h3A);
    rd(1'b0, 8'h3A);
    $display("test selector done");
  endtask

  task automatic test_revision();
    rd_reg(8'h00, REV_EXP);
    wr(1'b1, 8'hFF);
    rd(1'b1, REV_EXP);
    wr_rd(8'h00, 8'h5A, REV_EXP);
    $display("test revision done");
  endtask

  // Each socket shows its own card, the other one sees the inverse pattern
  task automatic test_status();
    for (int i = 0; i < 4; i++) begin
      cfg[0] = PAT[i];
      cfg[1] = ~PAT[i];
      rd_reg(8'h01, {PAT[i][6], 1'b0, PAT[i][5:0]});
      rd_reg(8'h41, {~PAT[i][6], 1'b0, ~PAT[i][5:0]});
    end
    wr_reg(8'h02, 8'h10);
    rd_reg(8'h01, {PAT[3][6], 1'b1, PAT[3][5:0]});
    $display("test status done");
  endtask

  task automatic test_power();
    wr_reg(8'h02, 8'hB3);
    chk(power[0], 8'hB3);
    chk(power[1], 8'h00);
    wr_reg(8'h42, 8'h4C);
    chk(power[1], 8'h4C);
    rd_reg(8'h02, 8'hB3);
    rd_reg(8'h42, 8'h4C);
    wr_rd(8'h42, 8'h91, 8'h91);
    chk(power[1], 8'h91);
    $display("test power done");
  endtask

  // Foreign device and read-only writes leave power byte 0 alone; foreign and unmapped reads give zero
  task automatic test_refused();
    wr_reg(8'h82, 8'hFF);
    chk(power[0], 8'hB3);
    rd(1'b1, 8'h00);
    rd_reg(8'h05, 8'h00);
    wr_reg(8'h01, 8'hFF);
    chk(power[0], 8'hB3);
    $display("test refused done");
  endtask

  // Reset in mid-run clears selector and both power bytes
  task automatic test_midreset();
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(power[0], 8'h00);
    chk(power[1], 8'h00);
    rd(1'b0, 8'h00);
    rd_reg(8'h02, 8'h00);
    $display("test midreset done");
  endtask

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    bad_count = 0; compares = 0;
    rst = 1'b1; hst_sel = 1'b0; hst_addr = 1'b0; hst_rd = 1'b0; hst_wr = 1'b0;
    hst_wdata = 8'h00; cfg[0] = 7'h00; cfg[1] = 7'h00;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    test_reset();
    test_selector();
    test_revision();
    test_status();
    test_power();
    test_refused();
    test_midreset();
    print_verdict();
  end

  // Watchdog, well beyond the roughly 120 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // card_socket_status_power_regs_tb_top

//--- bench/cssp_card_model.sv
// Purpose: Behavioural card seated in one socket, drives its pin levels
// Assumes: Levels are steady between host accesses
// Notes:   Card detects are active low, so a seated card pulls them down
`timescale 1ns/1ps
module cssp_card_model (
  input  wire logic                 vpp_ok,  // Programming voltage good
  input  wire logic                 ready,   // Card ready level
  input  wire logic                 wp,      // Write protect level
  input  wire logic [1:0]           seat,    // Detect contacts made, b then a
  input  wire logic [1:0]           batt,    // Battery detect levels, b then a
  output cssp_pkg::cssp_pins_t      pins     // Pin bundle to the socket
);
  // Half-seated cards are possible, so each detect follows its own contact
  assign pins = {~vpp_ok, ready, wp, ~seat[0], ~seat[1], batt[0], batt[1]};
endmodule // cssp_card_model

//--- hdl/cssp_pkg.sv
// Purpose: Shared constants and carrier types for the card socket status/power bank
// Assumes: Eight-bit registers reached through one selector byte and one data byte
// Notes:   Offsets are register numbers inside the selector, not bus addresses
package cssp_pkg;

  // Register numbers carried in the selector's low six bits
  localparam logic [5:0] CSSP_IDX_REVISION = 6'h00;  // Chip revision, read only
  localparam logic [5:0] CSSP_IDX_STATUS   = 6'h01;  // Socket pin status, read only
  localparam logic [5:0] CSSP_IDX_POWER    = 6'h02;  // Socket power control

  // Selector field positions
  localparam int CSSP_SEL_DEV_BIT  = 7;  // Device select
  localparam int CSSP_SEL_SOCK_BIT = 6;  // Socket select
  localparam int CSSP_SEL_REG_HI   = 5;  // Register number top bit

  // Reset values
  localparam logic [7:0] CSSP_SEL_RST   = 8'h00;  // Selector after reset
  localparam logic [7:0] CSSP_POWER_RST = 8'h00;  // Power control after reset
  localparam logic [7:0] CSSP_RD_IDLE   = 8'h00;  // Read data after reset, or on foreign or unmapped reads

  // Host port address values
  localparam logic CSSP_PORT_SELECTOR = 1'b0;  // Selector byte
  localparam logic CSSP_PORT_DATA     = 1'b1;  // Data byte

  // Cycles from a read strobe to its data
  localparam int CSSP_RD_LATENCY = 1;

  // Socket pins, all sampled as synchronous levels
  typedef struct packed {
    logic vpp_valid_n;              // Programming voltage valid, active low
    logic card_ready_irq;           // Ready or interrupt request
    logic card_wprot_io16;          // Write protect or 16-bit I/O
    logic card_detect_a_n;          // First card detect, active low
    logic card_detect_b_n;          // Second card detect, active low
    logic batt_detect_a_stschange;  // First battery detect
    logic batt_detect_b_speaker;    // Second battery detect
  } cssp_pins_t;

  // Power control layout, bit 7 down to bit 0
  typedef struct packed {
    logic       card_out_en;  // Card output enable
    logic       compat_hi;    // Compatibility bit, stored only
    logic       auto_power;   // Automatic power
    logic       vcc_on;       // Card supply control
    logic [1:0] compat_mid;   // Compatibility bits, stored only
    logic [1:0] vpp_ctl;      // Programming voltage control
  } cssp_power_t;

endpackage

//--- hdl/cssp_socket_slice.sv
// Purpose: One socket's power control register and pin status byte
// Assumes: Pins are synchronous to clk_sys; write strobe already decoded
// Notes:   Status byte is combinational; the caller registers read data
`timescale 1ns/1ps
module cssp_socket_slice (
  input  wire logic                 clk_sys,      // System clock
  input  wire logic                 rst,          // Async reset, active high
  input  wire cssp_pkg::cssp_pins_t pins,         // Socket pin levels
  input  wire logic                 power_we,     // Power register write strobe
  input  wire logic [7:0]           wdata,        // Write byte
  output logic [7:0]                status_byte,  // Pin status view
  output cssp_pkg::cssp_power_t     power         // Power control fields
);

  logic [7:0] power_r;  // Power control storage

  // Power control register, every bit read/write, cleared by reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_r <= cssp_pkg::CSSP_POWER_RST;
    end else if (power_we) begin
      power_r <= wdata;
    end
  end

  assign power = cssp_pkg::cssp_power_t'(power_r);

  // Status view; bit 6 shows the supply control so software sees power state
  assign status_byte = {~pins.vpp_valid_n,
                        power.vcc_on,
                        pins.card_ready_irq,
                        pins.card_wprot_io16,
                        ~pins.card_detect_b_n,
                        ~pins.card_detect_a_n,
                        pins.batt_detect_b_speaker,
                        pins.batt_detect_a_stschange};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_vpp_inverted: assert property (status_byte[7] == !pins.vpp_valid_n)
    else $error("Status bit 7 is not the inverted vpp valid pin");
  chk_detect_inverted: assert property (status_byte[3:2] ==
      ~{pins.card_detect_b_n, pins.card_detect_a_n})
    else $error("Card detect bits do not read inverted pins");
  chk_power_write: assert property (power_we |=> power_r == $past(wdata))
    else $error("Power control did not take the written byte");
  chk_power_hold: assert property (!power_we |=> $stable(power_r))
    else $error("Power control changed without a write");

endmodule // cssp_socket_slice

//--- hdl/cssp_status_power_regs.sv
// Purpose: Selector/data register pair with revision, pin status and power control
// Assumes: Host strobes are one-cycle pulses synchronous to clk_sys
// Notes:   Read data is registered and valid one cycle after the read strobe
//          Selector reads back on the selector address; data port follows it
//          Foreign device, absent socket and unmapped numbers read as zero
//          Writes to read-only or unmapped numbers are dropped silently
//          Status bit 6 mirrors the stored supply control of that socket
//
// Functional notes
// - Selector holds device, socket, register number
// - Revision register is read-only identity byte
// - Status bit 7 is inverted vpp valid
// - Status bit 5 is ready/irq pin
// - Status bit 4 is write-protect pin
// - Status bits 3:2 inverted card detects
// - Status bits 1:0 battery detect pins
// - Power control fields read/write, reset zero
`timescale 1ns/1ps
module cssp_status_power_regs #(
  parameter int         NUM_SOCKETS = 2,      // Sockets served, one or two
  parameter logic       DEVICE_SEL  = 1'b0,   // Device select value this chip answers
  parameter logic [1:0] IF_ID       = 2'h1,   // Interface id, arbitrary value
  parameter logic [4:0] REV_CODE    = 5'h04   // Stepping code, arbitrary value
) (
  input  wire logic                 clk_sys,    // System clock, 200 MHz
  input  wire logic                 rst,        // Async reset, active high
  // Host side byte port
  input  wire logic                 hst_sel,    // Chip select
  input  wire logic                 hst_addr,   // Zero selector, one data
  input  wire logic                 hst_rd,     // Read strobe
  input  wire logic                 hst_wr,     // Write strobe
  input  wire logic [7:0]           hst_wdata,  // Write byte
  output logic [7:0]                hst_rdata,  // Read byte, registered
  output logic                      hst_rvalid, // Read byte valid pulse
  // Socket side
  input  wire cssp_pkg::cssp_pins_t sock_pins  [2], // Pin levels per socket
  output cssp_pkg::cssp_power_t     sock_power [2]  // Power fields per socket
);

  // Host cycle, one clk_sys edge per access:
  //   hst_sel high with hst_wr writes hst_wdata to the selector or data port
  //   hst_sel high with hst_rd returns a byte one cycle later with hst_rvalid
  //   Accesses may come on every edge; a read in a write cycle sees old state
  // The selector names device, socket and register number; the data port then
  // reaches that register. Only register numbers 00h to 02h exist here.

  // Selector state
  logic [7:0] sel_r;    // Selector register
  logic [7:0] sel_nxt;  // Selector next value

  // Read path state
  logic [7:0] rdata_r;   // Registered read byte
  logic [7:0] rdata_nxt; // Read byte next value
  logic       rvalid_r;  // Read valid flag

  // Decoded host strobes
  // Strobes without chip select are ignored entirely
  wire logic       acc_sel   = hst_sel & (hst_addr == cssp_pkg::CSSP_PORT_SELECTOR);
  wire logic       acc_data  = hst_sel & (hst_addr == cssp_pkg::CSSP_PORT_DATA);
  wire logic       wr_sel    = acc_sel & hst_wr;   // Selector write
  wire logic       wr_data   = acc_data & hst_wr;  // Data port write
  wire logic       rd_any    = hst_sel & hst_rd;   // Any read

  // Selector fields
  // Positions come from the package so a remap stays in one place
  wire logic       sel_dev   = sel_r[cssp_pkg::CSSP_SEL_DEV_BIT];
  wire logic       sel_sock  = sel_r[cssp_pkg::CSSP_SEL_SOCK_BIT];
  wire logic [5:0] sel_reg   = sel_r[cssp_pkg::CSSP_SEL_REG_HI:0];

  // Device and socket match; another chip may share the port on a different select
  wire logic       dev_hit   = (sel_dev == DEVICE_SEL);
  wire logic       sock_ok   = (int'(sel_sock) < NUM_SOCKETS);
  wire logic       target_ok = dev_hit & sock_ok;

  // Register number decode
  // Only the low six bits; device and socket are judged above
  wire logic       is_rev    = (sel_reg == cssp_pkg::CSSP_IDX_REVISION);
  wire logic       is_stat   = (sel_reg == cssp_pkg::CSSP_IDX_STATUS);
  wire logic       is_pwr    = (sel_reg == cssp_pkg::CSSP_IDX_POWER);

  // Revision byte: id, a zero, then stepping code
  // Fixed at build time; a new stepping changes REV_CODE only
  wire logic [7:0] rev_byte  = {IF_ID, 1'b0, REV_CODE};

  // Per-socket views
  // Unpacked so each slice drives only its own element
  logic [7:0] status_b [2];  // Status bytes
  logic [7:0] power_b  [2];  // Power bytes
  logic       pwr_we   [2];  // Power write strobes

  // One slice per socket; absent sockets read zero and hold no state
  // A one-socket build thus costs no power register for the missing slot
  for (genvar i = 0; i < 2; i++) begin : g_sock
    if (i < NUM_SOCKETS) begin : g_live
      // Write lands only when the selector names this socket's power register
      assign pwr_we[i] = wr_data & target_ok & is_pwr & (int'(sel_sock) == i);
      cssp_socket_slice u_slice (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .pins        (sock_pins[i]),
        .power_we    (pwr_we[i]),
        .wdata       (hst_wdata),
        .status_byte (status_b[i]),
        .power       (sock_power[i])
      );
      assign power_b[i] = 8'(sock_power[i]);
    end else begin : g_none
      assign pwr_we[i]     = 1'b0;
      assign status_b[i]   = 8'h00;
      assign power_b[i]    = 8'h00;
      assign sock_power[i] = cssp_pkg::cssp_power_t'(cssp_pkg::CSSP_POWER_RST);
    end
  end

  // Selected socket's views, picked once so the read mux stays flat
  wire logic [7:0] stat_pick = status_b[sel_sock];  // Status of named socket
  wire logic [7:0] pwr_pick  = power_b[sel_sock];   // Power of named socket

  // Data port read value; unmapped numbers and foreign selects read zero
  // Zero keeps the byte defined whenever this chip is not the target
  wire logic [7:0] data_byte =
      !target_ok ? cssp_pkg::CSSP_RD_IDLE :
      is_rev     ? rev_byte :
      is_stat    ? stat_pick :
      is_pwr     ? pwr_pick :
                   cssp_pkg::CSSP_RD_IDLE;

  // Next selector value; a write replaces all eight bits
  // Device and socket bits move with the number, so one write retargets
  always_comb begin
    sel_nxt = sel_r;
    if (wr_sel) begin
      sel_nxt = hst_wdata;
    end
  end

  // Next read byte; held between reads so a slow host can still sample it
  // Captured from pre-edge state, so a same-cycle write is not seen
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_any) begin
      rdata_nxt = acc_sel ? sel_r : data_byte;
    end
  end

  // Selector register
  // Cleared by reset, so a first data access reaches the revision byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_r <= cssp_pkg::CSSP_SEL_RST;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Read data and its valid pulse
  // Valid is a one-cycle pulse; the byte itself stands until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r  <= cssp_pkg::CSSP_RD_IDLE;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rd_any;
    end
  end

  assign hst_rdata  = rdata_r;
  assign hst_rvalid = rvalid_r;

  // Checks and coverage
  // All checks pause while reset is high; values under reset are not judged
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Helper: expected status byte of the selected socket at read time
  // Built field by field from the pin bundle and sock_power, not from the slice's byte
  wire logic [7:0] exp_stat = {~sock_pins[sel_sock].vpp_valid_n,
                               sock_power[sel_sock].vcc_on,
                               sock_pins[sel_sock].card_ready_irq,
                               sock_pins[sel_sock].card_wprot_io16,
                               ~sock_pins[sel_sock].card_detect_b_n,
                               ~sock_pins[sel_sock].card_detect_a_n,
                               sock_pins[sel_sock].batt_detect_b_speaker,
                               sock_pins[sel_sock].batt_detect_a_stschange};

  // A data port read while this chip and socket are the target
  sequence s_data_read;
    acc_data && hst_rd && target_ok;
  endsequence

  // Selector: writes land, hold otherwise, read back at once
  chk_selector_write: assert property (wr_sel |=> sel_r == $past(hst_wdata))
    else $error("Selector did not take the written byte");

  chk_selector_hold: assert property (!wr_sel |=> $stable(sel_r))
    else $error("Selector changed without a write");

  chk_selector_read: assert property (acc_sel && hst_rd && !wr_sel |=>
      hst_rvalid && hst_rdata == $past(sel_r))
    else $error("Selector read returned a wrong byte");

  // Revision byte is fixed and ignores writes
  chk_revision_read: assert property (s_data_read ##0 is_rev |=>
      hst_rvalid && hst_rdata[5] == 1'b0 && hst_rdata == {IF_ID, 1'b0, REV_CODE})
    else $error("Revision read returned a wrong byte");

  chk_revision_ro: assert property (wr_data && is_rev && target_ok ##1
      acc_data && hst_rd && !wr_sel |=> hst_rdata == {IF_ID, 1'b0, REV_CODE})
    else $error("Revision changed after a write");

  // Status byte against the pins of the named socket
  chk_status_read: assert property (s_data_read ##0 is_stat |=>
      hst_rdata == $past(exp_stat))
    else $error("Status read does not follow the pins");

  chk_wprot_bit: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[4] == $past(sock_pins[sel_sock].card_wprot_io16))
    else $error("Write protect bit not read uninverted");

  chk_batt_bits: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[1:0] == $past({sock_pins[sel_sock].batt_detect_b_speaker,
                               sock_pins[sel_sock].batt_detect_a_stschange}))
    else $error("Battery detect bits not read uninverted");

  // Power write then read on consecutive edges
  chk_power_roundtrip: assert property (wr_data && is_pwr && target_ok ##1
      acc_data && hst_rd && $stable(sel_r) && !wr_data |=> hst_rdata == $past(hst_wdata, 2))
    else $error("Power control read back differs from write");

  // Another chip's select must leave the read byte at idle
  chk_foreign_device: assert property (hst_sel && hst_rd && hst_addr && !dev_hit |=>
      hst_rdata == cssp_pkg::CSSP_RD_IDLE)
    else $error("Foreign device select returned data");

  chk_read_latency: assert property (rd_any |->
      ##1 hst_rvalid ##1 !hst_rvalid || $past(rd_any))
    else $error("Read valid pulse malformed");

  // Read port timing: the byte moves only on a read, valid only after one
  chk_rdata_hold: assert property (!rd_any |=> $stable(hst_rdata))
    else $error("Read byte moved without a read");

  chk_rvalid_cause: assert property (hst_rvalid |-> $past(rd_any))
    else $error("Read valid without a read strobe");

  // Data port reads outside the three registers give the idle byte
  chk_unmapped_read: assert property (s_data_read ##0 !is_rev && !is_stat && !is_pwr |=>
      hst_rdata == cssp_pkg::CSSP_RD_IDLE)
    else $error("Unmapped register number returned data");

  // Status bits per pin, checked one by one for a clear failure message
  chk_vpp_read: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[7] == !$past(sock_pins[sel_sock].vpp_valid_n))
    else $error("Status bit 7 read is not the inverted vpp valid pin");

  chk_supply_bit: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[6] == $past(sock_power[sel_sock].vcc_on))
    else $error("Status bit 6 does not show the supply control");

  chk_ready_read: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[5] == $past(sock_pins[sel_sock].card_ready_irq))
    else $error("Ready bit not read uninverted");

  chk_detect_read: assert property (s_data_read ##0 is_stat |=>
      hst_rdata[3:2] == ~$past({sock_pins[sel_sock].card_detect_b_n,
                                sock_pins[sel_sock].card_detect_a_n}))
    else $error("Card detect bits not read inverted");

  // Power writes land only in the socket the selector names
  chk_power_sock0: assert property (wr_data && target_ok && is_pwr && !sel_sock |=>
      8'(sock_power[0]) == $past(hst_wdata))
    else $error("Socket 0 power did not take the write");

  chk_power_sock1: assert property (wr_data && target_ok && is_pwr && sel_sock |=>
      8'(sock_power[1]) == $past(hst_wdata))
    else $error("Socket 1 power did not take the write");

  chk_power_other0: assert property (wr_data && sel_sock |=> $stable(sock_power[0]))
    else $error("Socket 0 power changed on a socket 1 write");

  chk_power_other1: assert property (wr_data && !sel_sock |=> $stable(sock_power[1]))
    else $error("Socket 1 power changed on a socket 0 write");

  chk_power_refused: assert property (wr_data && !(target_ok && is_pwr) |=>
      $stable(sock_power[0]) && $stable(sock_power[1]))
    else $error("Refused write changed a power register");

  chk_power_readback: assert property (s_data_read ##0 is_pwr |=>
      hst_rdata == $past(8'(sock_power[sel_sock])))
    else $error("Power read does not match the stored byte");

  // Scenarios worth seeing at least once
  cov_power_write: cover property (wr_data && is_pwr && target_ok);
  cov_status_sock1: cover property (s_data_read ##0 is_stat && sel_sock);
  cov_revision_read: cover property (s_data_read ##0 is_rev);
  cov_unmapped_read: cover property (s_data_read ##0 !is_rev && !is_stat && !is_pwr);
  cov_write_then_read: cover property (wr_data && is_pwr && target_ok ##1
      s_data_read ##0 is_pwr);

endmodule // cssp_status_power_regs
